// file: verification/iac_analog_src.sv
// analog source model: comparator feeding the successive approximation steps
`timescale 1ns/1ps
module iac_analog_src (
	input wire logic [11:0] sar_trial, // trial code from the card
	input wire logic [11:0] level, // input level as an ideal code
	output logic comp_above // 1 = input at or above trial
);
	// ideal comparator, no noise, so the finished code must equal the level
	assign comp_above = (level >= sar_trial);
endmodule

// file: verification/isolated_adc_card_control_tb_top.sv
// testbench: host bus driver and scenarios for the card control logic
`timescale 1ns/1ps
module isolated_adc_card_control_tb_top;
	import iac_pkg::*;
	// short conversion keeps the run brief; step is (conv-2)/12 clocks
	localparam int CONV = 48;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [9:0] io_addr = 10'h000;
	logic io_wr = 1'b0;
	logic io_rd = 1'b0;
	logic [7:0] io_wdata = 8'h00;
	logic [5:0] sw = 6'h1D;
	logic jmp = 1'b0;
	logic [11:0] level = 12'h000;
	logic comp_above;
	logic [7:0] io_rdata;
	logic io_rdata_en;
	logic [4:0] chan;
	logic [1:0] gain;
	logic [11:0] sar_trial;
	logic pend;
	logic unip;
	int miscompares = 0;
	int checks = 0;
	iac_card_ctrl #(.CONV_CYCLES(CONV)) u_dut (.clk(clk), .sys_rst(sys_rst), .io_addr(io_addr), .io_wr(io_wr),
		.io_rd(io_rd), .io_wdata(io_wdata), .base_select_switch(sw), .range_polarity_jumper(jmp),
		.comp_above(comp_above), .io_rdata(io_rdata), .io_rdata_en(io_rdata_en), .channel_select(chan),
		.gain_select(gain), .sar_trial(sar_trial), .conversion_pending_flag(pend), .unipolar_mode(unip));
	iac_analog_src u_src (.sar_trial(sar_trial), .level(level), .comp_above(comp_above));
	always #25 clk = ~clk;
	////////////////////////////////////////////////////////////////
	task conclude;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input logic [11:0] got, input logic [11:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task step(input int n);
		repeat (n) @(posedge clk);
		#5;
	endtask
	// strobes are one cycle wide; the task returns 5 ns past the sampling edge
	task wr(input logic [9:0] a, input logic [7:0] d);
		step(1);
		io_addr = a;
		io_wdata = d;
		io_wr = 1'b1;
		step(1);
		io_wr = 1'b0;
	endtask
	task rd(input logic [9:0] a, output logic [7:0] d, output logic en);
		step(1);
		io_addr = a;
		io_rd = 1'b1;
		step(1);
		io_rd = 1'b0;
		d = io_rdata;
		en = io_rdata_en;
	endtask
	////////////////////////////////////////////////////////////////
	task t_regs;
		logic [7:0] d;
		logic en;
		chk({pend, gain, chan}, 12'h000);
		for (int g = 0; g < 4; g++) begin
			wr(10'h229, {6'b101010, g[1:0]});
			chk(gain, g[1:0]);
		end
		wr(10'h228, 8'h00);
		chk(gain, 2'h3);
		wr(10'h22A, 8'hFF);
		chk(chan, 5'h1F);
		wr(10'h22A, 8'hE0);
		chk(chan, 5'h00);
		rd(10'h220, d, en);
		chk({en, d}, 9'h100);
	endtask
	// base moves with the switch: all on gives 000, all off gives 3F0
	task t_decode;
		logic [7:0] d;
		logic en;
		sw = 6'h3F;
		step(4);
		wr(10'h009, 8'h01);
		chk(gain, 2'h1);
		wr(10'h229, 8'h02);
		chk(gain, 2'h1);
		sw = 6'h00;
		step(4);
		wr(10'h3F9, 8'h02);
		chk(gain, 2'h2);
		rd(10'h3EF, d, en);
		chk({en, d}, 9'h000);
		rd(10'h3FF, d, en);
		chk(en, 1'b1);
		sw = 6'h1D;
		step(4);
	endtask
	task t_convert(input logic [11:0] v, input logic [11:0] prev, input bit again);
		logic [7:0] d;
		logic en;
		realtime t0;
		int i;
		level = v;
		// a trigger while busy must restart the window and the sar
		if (again) begin
			wr(10'h22C, 8'h00);
			step(5);
		end
		wr(10'h22C, 8'hFF);
		t0 = $realtime;
		chk(pend, 1'b1);
		chk(sar_trial, 12'h800);
		rd(10'h225, d, en);
		chk(d[4:0], {1'b1, prev[11:8]});
		rd(10'h224, d, en);
		chk(d, prev[7:0]);
		for (i = 0; i < 2000 && pend === 1'b1; i++)
			step(1);
		if (i == 2000) begin
			miscompares++;
			$display("CHECK FAILED at %0t: pending never cleared", $time);
			conclude;
		end
		chk(($realtime - t0) / 50.0, CONV);
		rd(10'h224, d, en);
		chk({en, d}, {1'b1, v[7:0]});
		rd(10'h225, d, en);
		chk(d, {4'h0, v[11:8]});
	endtask
	task t_jumper;
		jmp = 1'b1;
		step(4);
		chk(unip, 1'b1);
		jmp = 1'b0;
		step(4);
		chk(unip, 1'b0);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		step(16);
		sys_rst = 1'b0;
		t_regs;
		t_decode;
		wr(10'h22A, 8'h07);
		t_convert(12'hA5C, 12'h000, 1'b0);
		t_convert(12'h3A7, 12'hA5C, 1'b0);
		t_convert(12'h0F1, 12'h3A7, 1'b1);
		t_jumper;
		conclude;
	end
endmodule

// file: verilog/iac_card_ctrl.sv
// top: address decode, control registers and conversion sequencing of the analog input card
// Notes on behaviour
// - card answers exactly sixteen consecutive addresses from base, ignores everything else
// - six-position switch compared against address lines A9 down to A4
// - switch on needs address line zero, off needs one
// - bases run 000 to 3F0 in steps of sixteen; low four bits ignored
// - shipped switch setting gives base 220
// - thirty-two inputs, one routed by host-written channel selection
// - every conversion yields a twelve-bit successive approximation result
// - conversion lasts 25 us; pending stays high throughout
// - only a software write starts a conversion
// - gain selectable among one, two, four and eight
// - polarity comes from a jumper; logic only reads and shows it
// - offset 4 reads result low byte; offset 5 high nibble plus pending
// - pending reads one during conversion, zero when result valid
// - offset 9 write sets two-bit gain code
`timescale 1ns/1ps
module iac_card_ctrl
	import iac_pkg::*;
#(
	parameter int CONV_CYCLES = iac_pkg::IAC_CONV_CYCLES // conversion length in clocks
) (
	input wire logic clk, // 20 MHz system clock
	input wire logic sys_rst, // synchronous reset, high
	input wire logic [9:0] io_addr, // host address lines A9..A0
	input wire logic io_wr, // host write strobe, one cycle
	input wire logic io_rd, // host read strobe, one cycle
	input wire logic [7:0] io_wdata, // host write data
	input wire logic [5:0] base_select_switch, // switch pos 1..6, 1 = on
	input wire logic range_polarity_jumper, // 1 = unipolar, 0 = bipolar
	input wire logic comp_above, // sar comparator result
	output logic [7:0] io_rdata, // read data, valid the cycle after io_rd
	output logic io_rdata_en, // read data is from this card
	output logic [4:0] channel_select, // input multiplexer select
	output logic [1:0] gain_select, // amplifier gain code
	output logic [11:0] sar_trial, // trial code to the dac
	output logic conversion_pending_flag, // conversion in progress
	output logic unipolar_mode // jumper state, synchronised
);
	import iac_pkg::*;

	initial begin
		if (CONV_CYCLES < IAC_RES_W + 2) $error("iac_card_ctrl: conversion too short for the sar");
	end

	// two spare clocks: the done pulse and the result capture both land before pending drops
	localparam int STEP = (CONV_CYCLES - 2) / IAC_RES_W;
	localparam int CNT_W = $clog2(CONV_CYCLES + 1);
	localparam logic [CNT_W-1:0] CONV_END = CNT_W'(CONV_CYCLES);

	logic [5:0] sw_s1, sw_s2;
	logic jp_s1, jp_s2;
	logic [5:0] base_match;
	logic hit;
	logic [$clog2(CONV_CYCLES+1)-1:0] conv_cnt;
	logic start;
	logic [11:0] sar_result;
	logic sar_done;
	logic [11:0] result;
	logic [CNT_W-1:0] chk_since;

	// true when the host address falls in this card's sixteen-address block
	function automatic logic in_block(input logic [9:0] a, input logic [5:0] sw);
		return a[9:4] == ~sw;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// switch and jumper are static pins: two flops before use
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sw_s1 <= ~IAC_DEFAULT_BASE;
			sw_s2 <= ~IAC_DEFAULT_BASE;
			jp_s1 <= 1'b0;
			jp_s2 <= 1'b0;
		end else begin
			sw_s1 <= base_select_switch;
			sw_s2 <= sw_s1;
			jp_s1 <= range_polarity_jumper;
			jp_s2 <= jp_s1;
		end
	end
	assign base_match = sw_s2;
	assign hit = in_block(io_addr, base_match);

	////////////////////////////////////////////////////////////////////////
	// jumper only observed, never driven
	always_ff @(posedge clk) begin
		if (sys_rst) unipolar_mode <= 1'b0;
		else unipolar_mode <= jp_s2;
	end

	////////////////////////////////////////////////////////////////////////
	// gain and channel registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			gain_select <= IAC_GAIN_RST;
			channel_select <= IAC_CHAN_RST;
		end else if (io_wr && hit) begin
			if (io_addr[3:0] == IAC_OFS_GAIN) gain_select <= io_wdata[1:0];
			if (io_addr[3:0] == IAC_OFS_CHANNEL) channel_select <= io_wdata[4:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// only a host write to the trigger offset starts; retrigger while busy restarts
	assign start = io_wr && hit && (io_addr[3:0] == IAC_OFS_TRIGGER);

	// pending flag held for the full conversion time by its own counter
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			conv_cnt <= '0;
			conversion_pending_flag <= 1'b0;
		end else if (start) begin
			conv_cnt <= ($clog2(CONV_CYCLES+1))'(CONV_CYCLES - 1);
			conversion_pending_flag <= 1'b1;
		end else if (conv_cnt != '0) begin
			conv_cnt <= conv_cnt - 1'b1;
		end else begin
			conversion_pending_flag <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sar engine; its steps finish inside the pending window
	iac_sar_engine #(
		.RES_W(IAC_RES_W),
		.STEP_CYCLES(STEP)
	) u_sar (
		.clk(clk),
		.sys_rst(sys_rst),
		.start(start),
		.comp_above(comp_above),
		.trial(sar_trial),
		.result(sar_result),
		.done(sar_done)
	);

	// result captured only at completion, so the old value stays readable meanwhile
	always_ff @(posedge clk) begin
		if (sys_rst) result <= IAC_RES_RST;
		else if (sar_done) result <= sar_result;
	end

	////////////////////////////////////////////////////////////////////////
	// read port: registered, zero for unmapped offsets
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			io_rdata <= 8'h00;
			io_rdata_en <= 1'b0;
		end else begin
			io_rdata_en <= io_rd && hit;
			if (io_rd && hit && io_addr[3:0] == IAC_OFS_RES_LOW) begin
				io_rdata <= result[7:0];
			end else if (io_rd && hit && io_addr[3:0] == IAC_OFS_RES_HIGH) begin
				io_rdata <= {3'b000, conversion_pending_flag, result[11:8]};
			end else begin
				io_rdata <= 8'h00;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	// independent age counter, so the window check does not lean on conv_cnt
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			chk_since <= CONV_END;
		end else if (start) begin
			chk_since <= '0;
		end else if (chk_since != CONV_END) begin
			chk_since <= chk_since + 1'b1;
		end
	end

	// pending window and conversion start
	chk_pend_on_start: assert property (@(posedge clk) disable iff (sys_rst)
		start |=> conversion_pending_flag) else $error("pending not set by trigger");
	chk_pend_hold: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(conversion_pending_flag) |-> conversion_pending_flag [*8]) else $error("pending dropped early");
	chk_pend_len: assert property (@(posedge clk) disable iff (sys_rst)
		conversion_pending_flag == (chk_since != CONV_END))
		else $error("pending window has the wrong length");
	chk_trigger_only: assert property (@(posedge clk) disable iff (sys_rst)
		(!start && !conversion_pending_flag) |=> !conversion_pending_flag)
		else $error("pending set without trigger");
	chk_done_inside: assert property (@(posedge clk) disable iff (sys_rst)
		sar_done |-> conversion_pending_flag) else $error("sar finished outside pending window");
	chk_trial_start: assert property (@(posedge clk) disable iff (sys_rst)
		start |=> sar_trial == {1'b1, {(IAC_RES_W-1){1'b0}}})
		else $error("first trial is not the top bit");
	// result and read port
	chk_result_stable: assert property (@(posedge clk) disable iff (sys_rst)
		!sar_done |=> $stable(result)) else $error("result changed without completion");
	chk_miss_ignored: assert property (@(posedge clk) disable iff (sys_rst)
		(io_rd && !hit) |=> !io_rdata_en) else $error("answered outside block");
	chk_rdata_idle: assert property (@(posedge clk) disable iff (sys_rst)
		!(io_rd && hit) |=> io_rdata == 8'h00) else $error("read data not idle");
	chk_low_byte: assert property (@(posedge clk) disable iff (sys_rst)
		(io_rd && hit && io_addr[3:0] == IAC_OFS_RES_LOW) |=> io_rdata == $past(result[7:0]))
		else $error("low byte does not match result");
	chk_high_byte: assert property (@(posedge clk) disable iff (sys_rst)
		(io_rd && hit && io_addr[3:0] == IAC_OFS_RES_HIGH) |=> io_rdata[7:5] == 3'b000)
		else $error("high byte upper bits not zero");
	// control registers
	chk_gain_write: assert property (@(posedge clk) disable iff (sys_rst)
		(io_wr && hit && io_addr[3:0] == IAC_OFS_GAIN) |=> gain_select == $past(io_wdata[1:0]))
		else $error("gain not written");
	chk_chan_value: assert property (@(posedge clk) disable iff (sys_rst)
		(io_wr && hit && io_addr[3:0] == IAC_OFS_CHANNEL) |=> channel_select == $past(io_wdata[4:0]))
		else $error("channel not written");
	chk_chan_write: assert property (@(posedge clk) disable iff (sys_rst)
		(io_wr && !hit) |=> $stable(channel_select)) else $error("channel changed by foreign write");
	// main scenarios
	cov_conversion: cover property (@(posedge clk) disable iff (sys_rst) start ##[1:600] sar_done);
	cov_read_high: cover property (@(posedge clk) disable iff (sys_rst)
		io_rd && hit && io_addr[3:0] == IAC_OFS_RES_HIGH);
	cov_retrigger: cover property (@(posedge clk) disable iff (sys_rst) conversion_pending_flag && start);
	cov_read_low: cover property (@(posedge clk) disable iff (sys_rst)
		io_rd && hit && io_addr[3:0] == IAC_OFS_RES_LOW);
	cov_base_zero: cover property (@(posedge clk) disable iff (sys_rst)
		io_wr && hit && io_addr[9:4] == 6'h00);
endmodule

// file: verilog/iac_pkg.sv
// package: constants for the isolated analog card control logic
package iac_pkg;
	// register offsets within the 16-address block
	localparam logic [3:0] IAC_OFS_RES_LOW = 4'h4;
	localparam logic [3:0] IAC_OFS_RES_HIGH = 4'h5;
	localparam logic [3:0] IAC_OFS_GAIN = 4'h9;
	localparam logic [3:0] IAC_OFS_CHANNEL = 4'hA;
	localparam logic [3:0] IAC_OFS_TRIGGER = 4'hC;
	// field positions and widths
	localparam int IAC_PENDING_BIT = 4;
	localparam int IAC_GAIN_W = 2;
	localparam int IAC_CHAN_W = 5;
	localparam int IAC_RES_W = 12;
	// address field of the shipped base of 0x220 (A9..A4 = 6'h22); the switch value is its complement
	localparam logic [5:0] IAC_DEFAULT_BASE = 6'h22;
	// reset values
	localparam logic [1:0] IAC_GAIN_RST = 2'h0;
	localparam logic [4:0] IAC_CHAN_RST = 5'h00;
	localparam logic [11:0] IAC_RES_RST = 12'h000;
	// timing
	localparam int IAC_CLK_HZ = 20_000_000;
	localparam int IAC_CONV_TIME_US = 25;
	localparam int IAC_CONV_CYCLES = (IAC_CONV_TIME_US * IAC_CLK_HZ + 999_999) / 1_000_000;
endpackage

// file: verilog/iac_sar_engine.sv
// successive approximation engine: one bit decided per step enable
`timescale 1ns/1ps
module iac_sar_engine #(
	parameter int RES_W = 12, // result width
	parameter int STEP_CYCLES = 41 // clocks per approximation step
) (
	input wire logic clk, // system clock
	input wire logic sys_rst, // synchronous reset, high
	input wire logic start, // one-cycle start pulse
	input wire logic comp_above, // comparator: input at or above trial value
	output logic [RES_W-1:0] trial, // trial code to the dac
	output logic [RES_W-1:0] result, // finished code
	output logic done // one-cycle completion pulse
);
	initial begin
		if (RES_W < 2 || STEP_CYCLES < 1) $error("iac_sar_engine: bad parameters");
	end

	logic [$clog2(STEP_CYCLES+1)-1:0] div;
	logic [RES_W-1:0] probe;
	logic busy;
	logic step;

	////////////////////////////////////////////////////////////////////////
	// step divider, restarted on start so the first step is full length
	always_ff @(posedge clk) begin
		if (sys_rst || start || !busy) begin
			div <= '0;
		end else if (step) begin
			div <= '0;
		end else begin
			div <= div + 1'b1;
		end
	end
	assign step = busy && (div == ($clog2(STEP_CYCLES+1))'(STEP_CYCLES - 1));

	////////////////////////////////////////////////////////////////////////
	// approximation register: msb first, one bit per step
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			busy <= 1'b0;
			trial <= '0;
			probe <= '0;
			result <= '0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				busy <= 1'b1;
				probe <= {1'b1, {(RES_W-1){1'b0}}};
				trial <= {1'b1, {(RES_W-1){1'b0}}};
			end else if (step) begin
				// keep or drop the bit under test, then try the next one
				if (probe[0]) begin
					busy <= 1'b0;
					done <= 1'b1;
					result <= comp_above ? trial : (trial & ~probe);
				end else begin
					trial <= (comp_above ? trial : (trial & ~probe)) | (probe >> 1);
					probe <= probe >> 1;
				end
			end
		end
	end
endmodule
